/* acra_core_model.sv */
`timescale 1ns/1ps
// converter core stand-in: answers each launch after a fixed latency
module acra_core_model #(
  parameter int unsigned LAT = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // launch side
  input wire logic core_start,
  input wire logic [2:0] core_chan,
  // answer side
  output logic core_done,
  output logic [9:0] core_data
);
  logic [7:0] cnt_r;
  logic [2:0] chan_r;
  // code carries the channel so the two slots' results differ;
  // data toggles outside done so a stale sample never matches
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
      chan_r <= 3'h0;
      core_done <= 1'b0;
      core_data <= 10'h3ff;
    end else begin
      core_done <= 1'b0;
      core_data <= ~core_data;
      if (core_start) begin
        cnt_r <= 8'(LAT);
        chan_r <= core_chan;
      end else if (cnt_r == 8'h01) begin
        cnt_r <= 8'h00;
        core_done <= 1'b1;
        core_data <= {chan_r, 7'h15};
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule

/* acra_pkg.sv */
package acra_pkg;

  // ----------------------------------------------------------------
  // register map (word indices on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_GLOBAL = 3'h0;
  localparam logic [2:0] ADDR_REQ = 3'h1;
  localparam logic [2:0] ADDR_RESULT0 = 3'h2;
  localparam logic [2:0] ADDR_RESULT1 = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_MASK = 3'h5;
  localparam int unsigned DATA_W = 24;
  localparam logic [23:0] RD_ZERO = 24'h00_0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // global control
  localparam int unsigned G_CONV_EN = 0;
  localparam int unsigned G_TRIG_IGN = 1;
  localparam int unsigned G_BATT_EN = 2;
  localparam int unsigned G_CELL_EN = 3;
  localparam int unsigned G_HALVE = 4;
  localparam int unsigned G_SEL_LO = 5;
  localparam int unsigned G_SEL_HI = 6;
  // per-request control; bit 23 picks the slot on writes
  localparam int unsigned Q_SW_START = 0;
  localparam int unsigned Q_BLOCK = 1;
  localparam int unsigned Q_ARM = 2;
  localparam int unsigned Q_CHAN_LO = 3;
  localparam int unsigned Q_SLOT_SEL = 23;
  // result word: code in 9:0, channel in 12:10
  localparam int unsigned R_CHAN_LO = 10;
  // status and mask
  localparam int unsigned S_DONE0 = 0;
  localparam int unsigned S_DONE1 = 1;
  localparam int unsigned S_SENSE = 2;
  localparam int unsigned S_BATT = 3;
  localparam int unsigned S_BUSY = 4;
  localparam int unsigned S_HOT = 5;

  // ----------------------------------------------------------------
  // channel 7 routing and die temperature
  // ----------------------------------------------------------------
  localparam logic [1:0] CH7_AUX_FIRST = 2'h0;
  localparam logic [1:0] CH7_DIE_TEMP = 2'h1;
  localparam logic [1:0] CH7_USB_ID = 2'h2;
  localparam logic [1:0] CH7_AUX_SECOND = 2'h3;
  localparam logic [2:0] CHAN_DIE = 3'h7;
  localparam logic [9:0] TEMP_CODE_25C = 10'h2a8;   // 680 decimal
  localparam real TEMP_C_PER_LSB = 0.4244;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_KHZ = 40000;
  localparam int unsigned DEBOUNCE_US = 1000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLOCK_KHZ / 1000;

  typedef enum logic {ST_IDLE, ST_WAIT} acra_state_t;

endpackage

/* acra_top.sv */
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - battery-removal compare on channel 5 runs only while its enable is set
// - sense bit follows the compare at once; its interrupt waits for a debounce
// - backup cell read enable routes channel 6 to the cell pin scaled 2/3
// - channel 7 select picks aux first, die temp, usb id half, aux second
// - halving applies only to the two auxiliary channel 7 inputs
// - die temperature reads 680 at 25 C, rising 0.4244 C per code
// - two request slots share one converter, each keeping settings and results
// - bit 23 of a request write picks the second slot, clear picks primary
// - slot select bit reads zero; second slot settings are never readable
// - each slot has its own result register, never overwritten by the other
// - each slot raises its own maskable done interrupt
// - with both slots queued the earlier triggered slot converts first
// - pin trigger for the idle slot is dropped when its cross block is set
// - otherwise that trigger is held and converts once the current one ends, after any same-edge re-trigger of a primary or blocking converting slot
// - cross block affects pin triggers only, never software starts
// - single shot accepts only the first pin trigger until software clears it
// - each slot has its own single shot arm bit
// - simultaneous pin triggers with equal cross block favour the primary slot
// - trigger ignore bit discards every external trigger pin transition
// - converter enable low ignores all pin triggers and software starts
module acra_top #(
  parameter int unsigned DEBOUNCE_CYCLES = acra_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  // trigger pin and battery comparator
  input wire logic external_trigger_pin,
  input wire logic batt_cmp_above,
  // converter core
  input wire logic core_done,
  input wire logic [9:0] core_data,
  output logic core_start,
  output logic [2:0] core_chan,
  // analog routing
  output logic batt_cmp_enable,
  output logic ch6_cell_scaled,
  output logic [1:0] ch7_route,
  output logic ch7_half,
  // interrupts
  output logic primary_done_irq,
  output logic second_done_irq,
  output logic battery_removal_irq
);

  initial begin
    if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES > 32'h00ff_ffff) begin
      $error("acra_top: DEBOUNCE_CYCLES out of range");
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic conv_en_r, trig_ign_r, batt_en_r, cell_en_r, halve_r;
  logic [1:0] sel_r, block_r, arm_r, shot_used_r, pend_r, done_r, mask_r;
  logic [2:0] chan_r [0:1];
  logic [12:0] result_r [0:1];
  logic batt_mask_r, batt_flag_r, sense_r, hot_r, trig_prev_r, older_r, active_r;
  logic [23:0] deb_cnt_r;
  acra_pkg::acra_state_t state_r;

  logic wr_glob, wr_req, wr_stat, wr_mask, wsel, ext_edge, tie, prio, pick, busy;
  logic [1:0] sw_start, ext_ok, req_set, launch, done_set;

  assign wr_glob = reg_wr && reg_addr == acra_pkg::ADDR_GLOBAL;
  assign wr_req = reg_wr && reg_addr == acra_pkg::ADDR_REQ;
  assign wr_stat = reg_wr && reg_addr == acra_pkg::ADDR_STATUS;
  assign wr_mask = reg_wr && reg_addr == acra_pkg::ADDR_MASK;
  assign wsel = reg_wdata[acra_pkg::Q_SLOT_SEL];
  assign busy = state_r == acra_pkg::ST_WAIT;

  // ----------------------------------------------------------------
  // global control register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      conv_en_r <= 1'b0;
      trig_ign_r <= 1'b0;
      batt_en_r <= 1'b0;
      cell_en_r <= 1'b0;
      halve_r <= 1'b0;
      sel_r <= acra_pkg::CH7_AUX_FIRST;
    end else if (wr_glob) begin
      conv_en_r <= reg_wdata[acra_pkg::G_CONV_EN];
      trig_ign_r <= reg_wdata[acra_pkg::G_TRIG_IGN];
      batt_en_r <= reg_wdata[acra_pkg::G_BATT_EN];
      cell_en_r <= reg_wdata[acra_pkg::G_CELL_EN];
      halve_r <= reg_wdata[acra_pkg::G_HALVE];
      sel_r <= {reg_wdata[acra_pkg::G_SEL_HI], reg_wdata[acra_pkg::G_SEL_LO]};
    end
  end

  // mask register: done masks in bits 1:0, battery mask in bit 3
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= 2'h0;
      batt_mask_r <= 1'b0;
    end else if (wr_mask) begin
      mask_r <= reg_wdata[acra_pkg::S_DONE1:acra_pkg::S_DONE0];
      batt_mask_r <= reg_wdata[acra_pkg::S_BATT];
    end
  end

  // ----------------------------------------------------------------
  // trigger qualification
  // ----------------------------------------------------------------
  // pin is taken as synchronous; only its rising edge triggers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= external_trigger_pin;
    end
  end

  assign ext_edge = external_trigger_pin && !trig_prev_r && conv_en_r && !trig_ign_r;
  // equal blocks favour primary; else the blocking slot goes first so the other is held
  assign tie = block_r[0] == block_r[1];
  assign prio = tie ? 1'b0 : block_r[1];
  assign pick = (pend_r == 2'b11) ? older_r : pend_r[1];

  // ----------------------------------------------------------------
  // per-slot settings, queue and results
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_slot
      // software start bypasses both cross block and single shot
      assign sw_start[s] = wr_req && wsel == s[0] && reg_wdata[acra_pkg::Q_SW_START]
                           && conv_en_r;
      assign ext_ok[s] = ext_edge && !(arm_r[s] && shot_used_r[s])
                         && !(busy && active_r != s[0] && block_r[s]);
      assign req_set[s] = sw_start[s] || ext_ok[s];
      assign launch[s] = !busy && pend_r != 2'b00 && pick == s[0];
      assign done_set[s] = busy && core_done && active_r == s[0];

      // slot controls, written only when bit 23 matches the slot
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          block_r[s] <= 1'b0;
          arm_r[s] <= 1'b0;
          chan_r[s] <= 3'h0;
        end else if (wr_req && wsel == s[0]) begin
          block_r[s] <= reg_wdata[acra_pkg::Q_BLOCK];
          arm_r[s] <= reg_wdata[acra_pkg::Q_ARM];
          chan_r[s] <= reg_wdata[acra_pkg::Q_CHAN_LO +: 3];
        end
      end

      // single shot spent on the first accepted pin trigger, re-armed by clearing arm
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          shot_used_r[s] <= 1'b0;
        end else if (!arm_r[s]) begin
          shot_used_r[s] <= 1'b0;
        end else if (ext_ok[s]) begin
          shot_used_r[s] <= 1'b1;
        end
      end

      // pending request; a new trigger wins over the launch that clears it
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          pend_r[s] <= 1'b0;
        end else if (req_set[s]) begin
          pend_r[s] <= 1'b1;
        end else if (launch[s]) begin
          pend_r[s] <= 1'b0;
        end
      end

      // result kept per slot so one slot never overwrites the other
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          result_r[s] <= 13'h0000;
        end else if (done_set[s]) begin
          result_r[s] <= {core_chan, core_data};
        end
      end

      // done flag: hardware set wins over the write-one clear
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          done_r[s] <= 1'b0;
        end else if (done_set[s]) begin
          done_r[s] <= 1'b1;
        end else if (wr_stat && reg_wdata[acra_pkg::S_DONE0 + s]) begin
          done_r[s] <= 1'b0;
        end
      end
    end
  endgenerate

  // arrival order among queued slots
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      older_r <= 1'b0;
    end else if (pend_r == 2'b00) begin
      older_r <= (req_set == 2'b11) ? prio : req_set[1];
    end else if (pend_r != 2'b11) begin
      older_r <= pend_r[1];
    end
  end

  // ----------------------------------------------------------------
  // shared converter sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= acra_pkg::ST_IDLE;
      active_r <= 1'b0;
      core_start <= 1'b0;
      core_chan <= 3'h0;
    end else begin
      core_start <= 1'b0;
      case (state_r)
        acra_pkg::ST_IDLE: begin
          if (pend_r != 2'b00) begin
            active_r <= pick;
            core_start <= 1'b1;
            core_chan <= chan_r[pick];
            state_r <= acra_pkg::ST_WAIT;
          end
        end
        acra_pkg::ST_WAIT: begin
          if (core_done) begin
            state_r <= acra_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= acra_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // die hotter than 25 C when a temperature result tops the 25 C code
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hot_r <= 1'b0;
    end else if (busy && core_done && core_chan == acra_pkg::CHAN_DIE
                 && sel_r == acra_pkg::CH7_DIE_TEMP) begin
      hot_r <= core_data > acra_pkg::TEMP_CODE_25C;
    end
  end

  // ----------------------------------------------------------------
  // analog routing
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ch6_cell_scaled <= 1'b0;
      ch7_route <= acra_pkg::CH7_AUX_FIRST;
      ch7_half <= 1'b0;
      batt_cmp_enable <= 1'b0;
    end else begin
      ch6_cell_scaled <= cell_en_r;
      ch7_route <= sel_r;
      ch7_half <= halve_r && (sel_r == acra_pkg::CH7_AUX_FIRST
                              || sel_r == acra_pkg::CH7_AUX_SECOND);
      batt_cmp_enable <= batt_en_r;
    end
  end

  // ----------------------------------------------------------------
  // battery removal: comparator trips at 31/32 of the bias output
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sense_r <= 1'b0;
    end else begin
      sense_r <= batt_en_r && batt_cmp_above;
    end
  end

  // debounce restarts whenever the sense bit drops
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      deb_cnt_r <= 24'h00_0000;
    end else if (!sense_r) begin
      deb_cnt_r <= 24'h00_0000;
    end else if (deb_cnt_r < DEBOUNCE_CYCLES[23:0]) begin
      deb_cnt_r <= deb_cnt_r + 24'h00_0001;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      batt_flag_r <= 1'b0;
    end else if (sense_r && deb_cnt_r == DEBOUNCE_CYCLES[23:0]) begin
      batt_flag_r <= 1'b1;
    end else if (wr_stat && reg_wdata[acra_pkg::S_BATT]) begin
      batt_flag_r <= 1'b0;
    end
  end

  // interrupt outputs, one cycle behind their flags
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      primary_done_irq <= 1'b0;
      second_done_irq <= 1'b0;
      battery_removal_irq <= 1'b0;
    end else begin
      primary_done_irq <= done_r[0] && !mask_r[0];
      second_done_irq <= done_r[1] && !mask_r[1];
      battery_removal_irq <= batt_flag_r && !batt_mask_r;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // results are stable only while no conversion runs; disabling first is advised
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= acra_pkg::RD_ZERO;
    end else if (!reg_rd) begin
      reg_rdata <= acra_pkg::RD_ZERO;
    end else if (reg_addr == acra_pkg::ADDR_GLOBAL) begin
      reg_rdata <= {17'h0_0000, sel_r, halve_r, cell_en_r, batt_en_r, trig_ign_r, conv_en_r};
    end else if (reg_addr == acra_pkg::ADDR_REQ) begin
      // primary slot only; select bit reads zero
      reg_rdata <= {18'h0_0000, chan_r[0], arm_r[0], block_r[0], 1'b0};
    end else if (reg_addr == acra_pkg::ADDR_RESULT0) begin
      reg_rdata <= {11'h000, result_r[0]};
    end else if (reg_addr == acra_pkg::ADDR_RESULT1) begin
      reg_rdata <= {11'h000, result_r[1]};
    end else if (reg_addr == acra_pkg::ADDR_STATUS) begin
      reg_rdata <= {18'h0_0000, hot_r, busy, batt_flag_r, sense_r, done_r};
    end else if (reg_addr == acra_pkg::ADDR_MASK) begin
      reg_rdata <= {20'h0_0000, batt_mask_r, 1'b0, mask_r};
    end else begin
      reg_rdata <= acra_pkg::RD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence finish_with_queue_s;
    busy && core_done && pend_r != 2'b00;
  endsequence

  sequence relaunch_s;
    ##2 core_start;
  endsequence

  sequence tie_triggers_s;
    !busy && pend_r == 2'b00 && ext_ok == 2'b11 && tie;
  endsequence

  start_single_a: assert property (@(posedge clock) disable iff (sys_rst)
    core_start |=> !core_start && busy) else $error("start not one cycle");
  queue_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
    finish_with_queue_s |-> relaunch_s) else $error("queued slot not started");
  tie_primary_a: assert property (@(posedge clock) disable iff (sys_rst)
    tie_triggers_s |=> ##1 (core_start && !active_r)) else $error("tie not primary");
  cross_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
    busy && !active_r && block_r[1] && !pend_r[1] && !sw_start[1]
    |=> !pend_r[1]) else $error("blocked trigger kept");
  cross_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
    busy && !active_r && !block_r[1] && ext_edge && !(arm_r[1] && shot_used_r[1])
    |=> pend_r[1]) else $error("trigger not remembered");
  enable_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    !conv_en_r && pend_r == 2'b00 |=> pend_r == 2'b00) else $error("start while off");
  ignore_pin_a: assert property (@(posedge clock) disable iff (sys_rst)
    trig_ign_r && !reg_wr && pend_r == 2'b00 |=> pend_r == 2'b00)
    else $error("pin not ignored");
  single_shot_a: assert property (@(posedge clock) disable iff (sys_rst)
    arm_r[0] && shot_used_r[0] && !reg_wr && !pend_r[0] |=> !pend_r[0])
    else $error("second shot taken");
  select_reads_a: assert property (@(posedge clock) disable iff (sys_rst)
    reg_rd && reg_addr == acra_pkg::ADDR_REQ |=> !reg_rdata[acra_pkg::Q_SLOT_SEL])
    else $error("select bit read back");
  result_apart_a: assert property (@(posedge clock) disable iff (sys_rst)
    done_set[0] |=> $stable(result_r[1]) && done_r[0]) else $error("result crossed");
  done_irq_a: assert property (@(posedge clock) disable iff (sys_rst)
    done_set[1] && !mask_r[1] && !wr_mask |=> ##1 second_done_irq)
    else $error("done irq missing");
  debounce_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(batt_flag_r) |-> $past(sense_r) && $past(deb_cnt_r) == DEBOUNCE_CYCLES[23:0])
    else $error("irq before debounce");
  sense_now_a: assert property (@(posedge clock) disable iff (sys_rst)
    batt_en_r && batt_cmp_above |=> sense_r) else $error("sense late");

endmodule

/* tb_acra_top.sv */
`timescale 1ns/1ps
module tb_acra_top;
  // design ports
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [23:0] reg_wdata = 24'h000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic external_trigger_pin = 1'b0;
  logic batt_cmp_above = 1'b0;
  logic [23:0] reg_rdata;
  logic core_done, core_start, batt_cmp_enable, ch6_cell_scaled, ch7_half;
  logic [9:0] core_data;
  logic [2:0] core_chan;
  logic [1:0] ch7_route;
  logic primary_done_irq, second_done_irq, battery_removal_irq;
  // bookkeeping
  int miscompares = 0;
  int cmp_count = 0;
  int starts = 0;
  int dones = 0;
  logic [2:0] chans[$];

  always #12.5 clock = ~clock;

  acra_top #(.DEBOUNCE_CYCLES(4)) dut (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_trigger_pin(external_trigger_pin),
    .batt_cmp_above(batt_cmp_above), .core_done(core_done), .core_data(core_data),
    .core_start(core_start), .core_chan(core_chan), .batt_cmp_enable(batt_cmp_enable),
    .ch6_cell_scaled(ch6_cell_scaled), .ch7_route(ch7_route), .ch7_half(ch7_half),
    .primary_done_irq(primary_done_irq), .second_done_irq(second_done_irq),
    .battery_removal_irq(battery_removal_irq));
  acra_core_model #(.LAT(12)) core (.clock(clock), .sys_rst(sys_rst),
    .core_start(core_start), .core_chan(core_chan), .core_done(core_done),
    .core_data(core_data));

  // launch log, sampled mid-cycle to stay clear of the edge
  always @(negedge clock) begin
    if (core_start === 1'b1) begin
      starts++;
      chans.push_back(core_chan);
    end
    if (core_done === 1'b1) begin
      dones++;
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // idle cycle after each strobe keeps a driver from assigning twice in one step
  task automatic wr(input logic [2:0] a, input logic [23:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [2:0] a, input logic [23:0] m, input logic [23:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    // read data stand for this one cycle only: look mid-cycle, clear of both edges
    @(negedge clock);
    chk(reg_rdata & m, exp);
    @(posedge clock);
  endtask
  function automatic logic [23:0] req(logic s, logic b, logic arm, logic [2:0] ch, logic go);
    return {s, 17'h0, ch, arm, b, go};
  endfunction
  task automatic pin();
    external_trigger_pin <= 1'b1;
    repeat (2) @(posedge clock);
    external_trigger_pin <= 1'b0;
    @(posedge clock);
  endtask
  // at least 40 cycles so a stray launch would still be seen
  task automatic await(input int n);
    for (int i = 0; i < 300; i++) begin
      if (i >= 40 && dones >= n) break;
      @(posedge clock);
    end
    repeat (3) @(posedge clock);
  endtask
  task automatic clr();
    starts = 0;
    dones = 0;
    chans.delete();
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog: the run needs well under 20000 cycles
  initial begin
    #500000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(acra_pkg::ADDR_MASK, 24'hffffff, 24'h0);
    wr(3'h7, 24'hffffff);
    rd(3'h7, 24'hffffff, 24'h0);
    // channel 6 and 7 routing with halving on
    for (int s = 0; s < 4; s++) begin
      wr(acra_pkg::ADDR_GLOBAL, 24'h00001c | (24'(s) << 5));
      @(posedge clock);
      chk({23'h0, ch6_cell_scaled}, 24'h1);
      chk({23'h0, batt_cmp_enable}, 24'h1);
      chk({22'h0, ch7_route}, 24'(s));
      chk({23'h0, ch7_half}, (s == 0 || s == 3) ? 24'h1 : 24'h0);
    end
    wr(acra_pkg::ADDR_GLOBAL, 24'h000060);
    @(posedge clock);
    chk({21'h0, ch6_cell_scaled, ch7_half, batt_cmp_enable}, 24'h0);
    // removal compare: dead while disabled, sense at once, irq after debounce
    batt_cmp_above <= 1'b1;
    repeat (12) @(posedge clock);
    rd(acra_pkg::ADDR_STATUS, 24'h00000c, 24'h0);
    wr(acra_pkg::ADDR_GLOBAL, 24'h000004);
    chk({23'h0, battery_removal_irq}, 24'h0);
    rd(acra_pkg::ADDR_STATUS, 24'h000004, 24'h000004);
    for (int i = 0; i < 30 && battery_removal_irq !== 1'b1; i++) @(posedge clock);
    chk({23'h0, battery_removal_irq}, 24'h1);
    batt_cmp_above <= 1'b0;
    // let sense drop first: while the set condition holds it wins over the clear
    repeat (2) @(posedge clock);
    wr(acra_pkg::ADDR_STATUS, 24'h000008);
    repeat (2) @(posedge clock);
    chk({23'h0, battery_removal_irq}, 24'h0);
    // two slots, separate results and done flags
    wr(acra_pkg::ADDR_GLOBAL, 24'h000001);
    wr(acra_pkg::ADDR_REQ, req(1, 0, 0, 3'h6, 0));
    wr(acra_pkg::ADDR_REQ, req(0, 1, 0, 3'h5, 0));
    rd(acra_pkg::ADDR_REQ, 24'hffffff, req(0, 1, 0, 3'h5, 0));
    wr(acra_pkg::ADDR_REQ, req(0, 1, 0, 3'h5, 1));
    await(1);
    wr(acra_pkg::ADDR_REQ, req(1, 0, 0, 3'h6, 1));
    await(2);
    wr(acra_pkg::ADDR_GLOBAL, 24'h000000);
    rd(acra_pkg::ADDR_RESULT0, 24'hffffff, {11'h0, 3'h5, 3'h5, 7'h15});
    rd(acra_pkg::ADDR_RESULT1, 24'hffffff, {11'h0, 3'h6, 3'h6, 7'h15});
    chk({22'h0, second_done_irq, primary_done_irq}, 24'h3);
    wr(acra_pkg::ADDR_MASK, 24'h000001);
    @(posedge clock);
    chk({22'h0, second_done_irq, primary_done_irq}, 24'h2);
    rd(acra_pkg::ADDR_STATUS, 24'h000003, 24'h000003);
    wr(acra_pkg::ADDR_STATUS, 24'h000003);
    @(posedge clock);
    rd(acra_pkg::ADDR_STATUS, 24'h000003, 24'h0);
    wr(acra_pkg::ADDR_MASK, 24'h000000);
    // disabled, then pin ignored
    clr();
    wr(acra_pkg::ADDR_REQ, req(0, 0, 0, 3'h5, 1));
    pin();
    await(0);
    chk(24'(starts), 24'h0);
    wr(acra_pkg::ADDR_GLOBAL, 24'h000003);
    pin();
    await(0);
    chk(24'(starts), 24'h0);
    // one pin edge, equal blocks: primary first
    wr(acra_pkg::ADDR_GLOBAL, 24'h000001);
    pin();
    await(2);
    chk({15'h0, 3'(chans.size()), chans[0], chans[1]}, {15'h0, 3'h2, 3'h5, 3'h6});
    // pin during a conversion: slot 1 dropped when blocked, held when not
    for (int b = 1; b >= 0; b--) begin
      wr(acra_pkg::ADDR_REQ, req(1, b[0], 0, 3'h6, 0));
      clr();
      wr(acra_pkg::ADDR_REQ, req(0, 0, 0, 3'h5, 1));
      for (int i = 0; i < 20 && starts < 1; i++) @(posedge clock);
      pin();
      await(3 - b);
      chk(24'(starts), 24'(3 - b));
    end
    // single shot on the primary slot only
    wr(acra_pkg::ADDR_REQ, req(0, 0, 1, 3'h5, 0));
    clr();
    pin();
    await(2);
    pin();
    await(3);
    chk({21'h0, chans[2]}, 24'h6);
    chk(24'(starts), 24'h3);
    wr(acra_pkg::ADDR_REQ, req(0, 0, 0, 3'h5, 0));
    wr(acra_pkg::ADDR_REQ, req(0, 0, 1, 3'h5, 0));
    clr();
    pin();
    await(2);
    chk(24'(starts), 24'h2);
    // die temperature reading above the 25 C code
    wr(acra_pkg::ADDR_GLOBAL, 24'h000021);
    clr();
    wr(acra_pkg::ADDR_REQ, req(0, 0, 0, 3'h7, 1));
    await(1);
    rd(acra_pkg::ADDR_STATUS, 24'h000020,
      ({3'h7, 7'h15} > acra_pkg::TEMP_CODE_25C) ? 24'h000020 : 24'h0);
    wrap_up();
  end
endmodule
